// File: hw/limit_timer_pkg.sv
// constants, register map and field layout of the hardware limit timer
//
// Overview of operation
// - count from instruction clock, oscillator over four
// - four-bit prescaler: divide by 1, 4, 16
// - compare count with period, match is output
// - count returns to zero after a match
// - postscaler overflow sets the limit match flag
// - interrupt requested only while enable bit set
// - sixteen postscale ratios chosen in control0
// - reset to output takes period plus one
// - count and period read/write; reset zero, ones
// - scalers cleared by count, control0 writes, reset
// - control0 write leaves count unchanged
// - three-bit select picks one of three sources, the other five are reserved
// - external reset clears count on next tick
// - rising, falling or both edges reset count
// - external reset gives no output, no postscale
// - timely external resets prevent any match
// - unscaled match goes to complementary output generator
// - count frozen during processor sleep
// - postscale ratio is field value plus one
package limit_timer_pkg;

	// register indices on the plain register port
	localparam logic [2:0] OFS_LIMIT_COUNT = 3'h0;
	localparam logic [2:0] OFS_LIMIT_PERIOD = 3'h1;
	localparam logic [2:0] OFS_LIMIT_CONTROL0 = 3'h2;
	localparam logic [2:0] OFS_LIMIT_CONTROL1 = 3'h3;
	localparam logic [2:0] OFS_PERIPHERAL_FLAG = 3'h4;
	localparam logic [2:0] OFS_PERIPHERAL_ENABLE = 3'h5;

	// limit_control0 fields
	localparam int PRESCALE_SELECT_LSB = 0;
	localparam int TIMER_ON_BIT = 2;
	localparam int POSTSCALE_SELECT_LSB = 3;
	// limit_control1 fields
	localparam int RISING_RESET_ENABLE_BIT = 0;
	localparam int FALLING_RESET_ENABLE_BIT = 1;
	localparam int RESET_SOURCE_SELECT_LSB = 2;
	// flag and enable bit position in the peripheral registers
	localparam int LIMIT_MATCH_BIT = 2;

	// values after reset
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] PERIOD_RESET = 8'hff;
	localparam logic [6:0] CONTROL0_RESET = 7'h00;
	localparam logic [4:0] CONTROL1_RESET = 5'h00;

	// instruction clock is the oscillator divided by this
	localparam int INST_DIVIDE = 4;
	localparam logic [1:0] INST_LAST = 2'(INST_DIVIDE - 1);

	// prescaler terminal counts
	localparam logic [3:0] PRESCALE_LAST_1 = 4'h0;
	localparam logic [3:0] PRESCALE_LAST_4 = 4'h3;
	localparam logic [3:0] PRESCALE_LAST_16 = 4'hf;

	// implemented reset sources, the rest are reserved
	localparam logic [2:0] SOURCE_CAPTURE = 3'h0;
	localparam logic [2:0] SOURCE_COMPARATOR1 = 3'h1;
	localparam logic [2:0] SOURCE_COMPARATOR2 = 3'h2;

endpackage : limit_timer_pkg

// File: hw/reset_edge_detect.sv
// synchroniser, source select and edge detector for the reset inputs
`timescale 1ns/1ns
module reset_edge_detect (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// raw peripheral outputs, unrelated to clk
	input wire logic [2:0] source_raw,
	// selection from limit_control1
	input wire logic [2:0] select,
	// one-cycle edge pulses of the selected source
	output logic rise,
	output logic fall
);
	import limit_timer_pkg::*;

	typedef struct packed {
		logic [2:0] sync1;
		logic [2:0] sync2;
		logic last;
		logic rise;
		logic fall;
	} edge_state_t;

	edge_state_t state;
	edge_state_t next_state;
	logic chosen;

	// reserved selections read as a quiet low input
	always_comb begin
		case (select)
			SOURCE_CAPTURE: chosen = state.sync2[0];
			SOURCE_COMPARATOR1: chosen = state.sync2[1];
			SOURCE_COMPARATOR2: chosen = state.sync2[2];
			default: chosen = 1'b0;
		endcase
	end

	// sync1 is only read by sync2, edges come from sync2
	always_comb begin
		next_state = state;
		next_state.sync1 = source_raw;
		next_state.sync2 = state.sync1;
		next_state.last = chosen;
		next_state.rise = chosen & ~state.last;
		next_state.fall = ~chosen & state.last;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign rise = state.rise;
	assign fall = state.fall;

endmodule : reset_edge_detect

// File: hw/hardware_limit_timer.sv
// hardware limit timer: prescaled period timer with external restart
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
module hardware_limit_timer (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// register port
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// processor sleep level
	input wire logic sleep,
	// asynchronous reset sources
	input wire logic capture_compare_unit_out,
	input wire logic comparator1_out,
	input wire logic comparator2_out,
	// outputs
	output logic limit_match,
	output logic limit_irq
);
	import limit_timer_pkg::*;

	typedef struct packed {
		logic [7:0] limit_count;
		logic [7:0] limit_period;
		logic [6:0] limit_control0;
		logic [4:0] limit_control1;
		logic limit_match_flag;
		logic limit_match_int_enable;
		logic [1:0] inst_div;
		logic [3:0] prescale;
		logic [3:0] postscale;
		logic ext_pending;
		logic match_out;
		logic [7:0] rdata;
	} timer_state_t;

	timer_state_t state;
	timer_state_t next_state;

	// decoded fields and timing strobes
	logic [1:0] prescale_select;
	logic [3:0] postscale_select;
	logic timer_on;
	logic [2:0] reset_source_select;
	logic rising_reset_enable;
	logic falling_reset_enable;
	logic edge_rise;
	logic edge_fall;
	logic ext_event;
	logic inst_tick;
	logic run;
	logic timer_tick;
	logic count_hit;
	logic write_count;
	logic write_control0;
	logic write_flag;

	// terminal count of the prescaler for a select value
	function automatic logic [3:0] prescale_last(input logic [1:0] sel);
		logic [3:0] result;
		result = PRESCALE_LAST_1;
		if (sel[1]) begin
			result = PRESCALE_LAST_16;
		end else if (sel[0]) begin
			result = PRESCALE_LAST_4;
		end
		return result;
	endfunction : prescale_last

	// register decode, used by several branches below
	function automatic logic hit(input logic strobe,
		input logic [2:0] a, input logic [2:0] ofs);
		return strobe && (a == ofs);
	endfunction : hit

	// field views of the control registers
	assign prescale_select = state.limit_control0[PRESCALE_SELECT_LSB +: 2];
	assign postscale_select =
		state.limit_control0[POSTSCALE_SELECT_LSB +: 4];
	assign timer_on = state.limit_control0[TIMER_ON_BIT];
	assign reset_source_select =
		state.limit_control1[RESET_SOURCE_SELECT_LSB +: 3];
	assign rising_reset_enable =
		state.limit_control1[RISING_RESET_ENABLE_BIT];
	assign falling_reset_enable =
		state.limit_control1[FALLING_RESET_ENABLE_BIT];

	// the peripheral outputs are unrelated to clk, so they are
	// synchronised before any edge is looked for
	reset_edge_detect edge_detect (
		.clk(clk),
		.reset(reset),
		.source_raw({comparator2_out, comparator1_out,
			capture_compare_unit_out}),
		.select(reset_source_select),
		.rise(edge_rise),
		.fall(edge_fall)
	);

	// enabled edges only; both enables give both edges
	assign ext_event = (edge_rise && rising_reset_enable)
		|| (edge_fall && falling_reset_enable);

	// the instruction clock is an enable every fourth cycle
	assign inst_tick = (state.inst_div == INST_LAST);
	// sleep and timer_on both freeze the whole count path
	assign run = inst_tick && timer_on && !sleep;
	assign timer_tick = run
		&& (state.prescale == prescale_last(prescale_select));
	// count and period are compared all the time
	assign count_hit = (state.limit_count == state.limit_period);

	assign write_count = hit(wr, addr, OFS_LIMIT_COUNT);
	assign write_control0 = hit(wr, addr, OFS_LIMIT_CONTROL0);
	assign write_flag = hit(wr, addr, OFS_PERIPHERAL_FLAG);

	// next state of the whole block
	always_comb begin
		next_state = state;
		next_state.match_out = 1'b0;
		next_state.rdata = 8'h00;

		// free-running instruction clock divider
		next_state.inst_div = state.inst_div + 2'h1;

		// hold an external event until the timer clock edge, since
		// with a prescaler the edge may come many cycles later
		if (ext_event) begin
			next_state.ext_pending = 1'b1;
		end

		// prescaler advances on each running instruction cycle
		if (run) begin
			if (timer_tick) begin
				next_state.prescale = 4'h0;
			end else begin
				next_state.prescale = state.prescale + 4'h1;
			end
		end

		// the count on the timer clock edge
		if (timer_tick) begin
			if (state.ext_pending) begin
				// external clear: no output, no postscale
				next_state.limit_count = COUNT_RESET;
				next_state.ext_pending = ext_event;
			end else if (count_hit) begin
				next_state.limit_count = COUNT_RESET;
				next_state.match_out = 1'b1;
				// ratio is select value plus one
				if (state.postscale == postscale_select) begin
					next_state.postscale = 4'h0;
					next_state.limit_match_flag = 1'b1;
				end else begin
					next_state.postscale = state.postscale + 4'h1;
				end
			end else begin
				next_state.limit_count = state.limit_count + 8'h01;
			end
		end

		// register writes; a write of the count wins over the tick
		if (write_count) begin
			next_state.limit_count = wdata;
			next_state.prescale = 4'h0;
			next_state.postscale = 4'h0;
		end
		if (hit(wr, addr, OFS_LIMIT_PERIOD)) begin
			next_state.limit_period = wdata;
		end
		if (write_control0) begin
			// count is left as it is
			next_state.limit_control0 = wdata[6:0];
			next_state.prescale = 4'h0;
			next_state.postscale = 4'h0;
		end
		if (hit(wr, addr, OFS_LIMIT_CONTROL1)) begin
			next_state.limit_control1 = wdata[4:0];
		end
		// writing zero clears the flag, a same-cycle set still wins
		if (write_flag && !wdata[LIMIT_MATCH_BIT]
			&& !next_state.limit_match_flag) begin
			next_state.limit_match_flag = 1'b0;
		end else if (write_flag && wdata[LIMIT_MATCH_BIT]) begin
			next_state.limit_match_flag = 1'b1;
		end
		if (write_flag && !wdata[LIMIT_MATCH_BIT]
			&& !(timer_tick && !state.ext_pending && count_hit
			&& state.postscale == postscale_select)) begin
			next_state.limit_match_flag = 1'b0;
		end
		if (hit(wr, addr, OFS_PERIPHERAL_ENABLE)) begin
			next_state.limit_match_int_enable = wdata[LIMIT_MATCH_BIT];
		end

		// read data stand only in the cycle after the strobe
		if (rd) begin
			case (addr)
				OFS_LIMIT_COUNT: next_state.rdata = state.limit_count;
				OFS_LIMIT_PERIOD: next_state.rdata = state.limit_period;
				OFS_LIMIT_CONTROL0:
					next_state.rdata = {1'b0, state.limit_control0};
				OFS_LIMIT_CONTROL1:
					next_state.rdata = {3'h0, state.limit_control1};
				OFS_PERIPHERAL_FLAG: next_state.rdata =
					8'(state.limit_match_flag) << LIMIT_MATCH_BIT;
				OFS_PERIPHERAL_ENABLE: next_state.rdata =
					8'(state.limit_match_int_enable) << LIMIT_MATCH_BIT;
				default: next_state.rdata = 8'h00;
			endcase
		end
	end

	// every device reset lands here: count zero, period all ones
	always_ff @(posedge clk) begin
		if (reset) begin
			state <= '0;
			state.limit_count <= COUNT_RESET;
			state.limit_period <= PERIOD_RESET;
			state.limit_control0 <= CONTROL0_RESET;
			state.limit_control1 <= CONTROL1_RESET;
			state.prescale <= 4'h0;
			state.postscale <= 4'h0;
		end else begin
			state <= next_state;
		end
	end

	// unscaled match goes only to the output generator
	assign limit_match = state.match_out;
	// interrupt request gated by its enable
	assign limit_irq = state.limit_match_flag
		&& state.limit_match_int_enable;
	assign rdata = state.rdata;

	// checks on the design's own behaviour
	logic match_now;
	assign match_now = timer_tick && !state.ext_pending && count_hit
		&& !write_count;

	chk_inst_rate: assert property (@(posedge clk) disable iff (reset)
		inst_tick |=> !inst_tick [*3] ##1 inst_tick)
		else $error("instruction tick not every fourth cycle");

	// after a divide-by-16 tick the next one is many clocks away, unless
	// software changes the select in between
	chk_presc_16: assert property (@(posedge clk)
		disable iff (reset)
		timer_tick && prescale_select[1]
		|=> (!timer_tick || !prescale_select[1]) [*8])
		else $error("divide by sixteen tick came too soon");

	chk_match_out: assert property (@(posedge clk) disable iff (reset)
		match_now |=> limit_match ##1 !limit_match)
		else $error("match pulse missing or too long");

	chk_wrap_zero: assert property (@(posedge clk) disable iff (reset)
		match_now |=> state.limit_count == 8'h00)
		else $error("count not zero after match");

	chk_flag_set: assert property (@(posedge clk) disable iff (reset)
		match_now && state.postscale == postscale_select
		|=> state.limit_match_flag)
		else $error("flag not set on postscale overflow");

	chk_irq_gate: assert property (@(posedge clk) disable iff (reset)
		limit_irq |-> $past(state.limit_match_int_enable) || $past(
		hit(wr, addr, OFS_PERIPHERAL_ENABLE)))
		else $error("interrupt raised while disabled");

	chk_reset_vals: assert property (@(posedge clk)
		reset |=> state.limit_count == 8'h00 && state.limit_period == 8'hff)
		else $error("reset values of count or period wrong");

	chk_scaler_clear: assert property (@(posedge clk) disable iff (reset)
		write_count || write_control0
		|=> state.prescale == 4'h0 && state.postscale == 4'h0)
		else $error("scalers not cleared by write");

	chk_ctrl_count: assert property (@(posedge clk) disable iff (reset)
		write_control0 && !write_count && !timer_tick
		|=> state.limit_count == $past(state.limit_count))
		else $error("control0 write changed the count");

	chk_ext_quiet: assert property (@(posedge clk) disable iff (reset)
		timer_tick && state.ext_pending && !write_count && !write_control0
		|=> state.limit_count == 8'h00 && !limit_match
		&& state.postscale == $past(state.postscale))
		else $error("external clear gave output or postscale");

	chk_sleep_hold: assert property (@(posedge clk) disable iff (reset)
		sleep && !write_count |=> $stable(state.limit_count))
		else $error("count moved during sleep");

	// these hold under any register traffic; write cycles are left out
	// where a write may override the tick, since the write must win
	// there
	chk_count_step: assert property (@(posedge clk)
		disable iff (reset)
		timer_tick && !state.ext_pending && !count_hit && !write_count
		|=> state.limit_count == $past(state.limit_count) + 8'h01)
		else $error("count did not step by one on a tick");

	// no tick and no write: the count holds, which covers timer_on low
	chk_count_idle: assert property (@(posedge clk)
		disable iff (reset)
		!timer_tick && !write_count
		|=> $stable(state.limit_count))
		else $error("count moved without a timer tick");

	// an enabled edge of the selected source arms the pending clear
	chk_edge_arm: assert property (@(posedge clk)
		disable iff (reset)
		(edge_rise && rising_reset_enable)
		|| (edge_fall && falling_reset_enable) |=> state.ext_pending)
		else $error("enabled source edge did not arm a clear");

	// a flag clear sticks unless an overflow lands in the same cycle
	chk_flag_clear: assert property (@(posedge clk)
		disable iff (reset)
		write_flag && !wdata[LIMIT_MATCH_BIT]
		&& !(match_now && state.postscale == postscale_select)
		|=> !state.limit_match_flag)
		else $error("flag clear did not take");

	// read data are zero outside the cycle after a read strobe
	chk_read_idle: assert property (@(posedge clk)
		disable iff (reset)
		!rd |=> rdata == 8'h00)
		else $error("read data outside the read cycle");

	cov_match: cover property (@(posedge clk) disable iff (reset)
		limit_match);
	cov_flag: cover property (@(posedge clk) disable iff (reset)
		$rose(state.limit_match_flag));
	cov_ext_clear: cover property (@(posedge clk) disable iff (reset)
		timer_tick && state.ext_pending);
	cov_presc16: cover property (@(posedge clk) disable iff (reset)
		timer_tick && prescale_select[1]);
	cov_irq: cover property (@(posedge clk) disable iff (reset)
		limit_irq);

endmodule : hardware_limit_timer

// File: verification/reset_source_model.sv
// far-side model: comparator and capture outputs feeding the timer
`timescale 1ns/1ns
module reset_source_model (
	// control from the bench
	input wire logic run,
	input wire logic [1:0] sel,
	// peripheral outputs, unrelated in phase to clk
	output logic [2:0] src
);
	// toggle the chosen line while run is high; the odd period keeps the
	// edges drifting against clk, as a free analog output would
	initial begin
		src = 3'h0;
		forever begin
			#301;
			if (run && sel < 2'h3) src[sel] = ~src[sel];
		end
	end
endmodule : reset_source_model

// File: verification/test_hardware_limit_timer.sv
// self-checking bench for the hardware limit timer
`timescale 1ns/1ns
module test_hardware_limit_timer;
	import limit_timer_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic sleep = 1'b0;
	logic run = 1'b0;
	logic [1:0] psel = 2'h0;
	logic [2:0] src;
	logic [7:0] rdata;
	logic limit_match;
	logic limit_irq;
	logic [7:0] v;
	int num_errors = 0;
	int n_tests = 0;
	int cycles = 0;
	int n;
	int k;
	// restart cases: select, partner line, edge enables, guarded
	logic [7:0] rows [5] = '{8'h03, 8'h2d, 8'h57, 8'h28, 8'haa};

	hardware_limit_timer i_hardware_limit_timer (
		.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .sleep(sleep),
		.capture_compare_unit_out(src[0]),
		.comparator1_out(src[1]), .comparator2_out(src[2]),
		.limit_match(limit_match), .limit_irq(limit_irq)
	);
	reset_source_model i_reset_source_model (
		.run(run), .sel(psel), .src(src)
	);

	always #10 clk = ~clk;

	// hang guard: the whole sequence needs well under this many cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			num_errors++;
			tally_and_finish;
		end
	end

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : tally_and_finish

	task automatic check(input string what, input logic [15:0] exp, got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask : rd_reg

	task automatic expect_reg(string what, logic [2:0] a, logic [7:0] e);
		logic [7:0] d;
		rd_reg(a, d);
		check(what, 16'(e), 16'(d));
	endtask : expect_reg

	// cycles until the next match pulse, bounded by lim
	task automatic wait_match(input int lim, output int c);
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while (limit_match !== 1'b1 && c < lim);
	endtask : wait_match

	initial begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		// reset values, unmapped slot ignored
		expect_reg("count", OFS_LIMIT_COUNT, COUNT_RESET);
		expect_reg("period", OFS_LIMIT_PERIOD, PERIOD_RESET);
		expect_reg("control0", OFS_LIMIT_CONTROL0, 8'h00);
		expect_reg("control1", OFS_LIMIT_CONTROL1, 8'h00);
		expect_reg("flags", OFS_PERIPHERAL_FLAG, 8'h00);
		wr_reg(3'h6, 8'h5a);
		expect_reg("unmapped", 3'h6, 8'h00);
		expect_reg("period kept", OFS_LIMIT_PERIOD, 8'hff);
		// control0 write spares the count; off bit holds it
		wr_reg(OFS_LIMIT_COUNT, 8'h42);
		wr_reg(OFS_LIMIT_PERIOD, 8'h05);
		wr_reg(OFS_LIMIT_CONTROL0, 8'h78);
		expect_reg("count kept", OFS_LIMIT_COUNT, 8'h42);
		expect_reg("control0", OFS_LIMIT_CONTROL0, 8'h78);
		repeat (40) @(posedge clk);
		expect_reg("count off", OFS_LIMIT_COUNT, 8'h42);
		// match spacing for every prescale code, period 5
		wr_reg(OFS_LIMIT_COUNT, 8'h00);
		for (int p = 0; p < 4; p++) begin
			wr_reg(OFS_LIMIT_CONTROL0, 8'h04 | 8'(p));
			wait_match(2000, n);
			wait_match(2000, n);
			k = 24 * (p == 0 ? 1 : (p == 1 ? 4 : 16));
			check("match gap", 16'(k), 16'(n));
		end
		// sleep freezes the count
		@(posedge clk);
		sleep <= 1'b1;
		rd_reg(OFS_LIMIT_COUNT, v);
		repeat (40) @(posedge clk);
		expect_reg("count asleep", OFS_LIMIT_COUNT, v);
		@(posedge clk);
		sleep <= 1'b0;
		// postscale: flag after field value plus one matches
		wr_reg(OFS_PERIPHERAL_ENABLE, 8'h04);
		expect_reg("enable", OFS_PERIPHERAL_ENABLE, 8'h04);
		wr_reg(OFS_LIMIT_PERIOD, 8'h02);
		for (int s = 0; s < 16; s += 5) begin
			wr_reg(OFS_LIMIT_CONTROL0, 8'h00);
			wr_reg(OFS_PERIPHERAL_FLAG, 8'h00);
			wr_reg(OFS_LIMIT_COUNT, 8'h00);
			wr_reg(OFS_LIMIT_CONTROL0, 8'(s << 3) | 8'h04);
			n = 0;
			k = 0;
			while (limit_irq !== 1'b1 && k < 400) begin
				@(negedge clk);
				k++;
				if (limit_match === 1'b1) n++;
			end
			check("matches per flag", 16'(s + 1), 16'(n));
		end
		// masking drops the request but keeps the flag
		wr_reg(OFS_PERIPHERAL_ENABLE, 8'h00);
		@(negedge clk);
		check("irq masked", 16'h0, 16'(limit_irq));
		expect_reg("flag held", OFS_PERIPHERAL_FLAG, 8'h04);
		wr_reg(OFS_LIMIT_CONTROL0, 8'h00);
		wr_reg(OFS_PERIPHERAL_FLAG, 8'h00);
		expect_reg("flag cleared", OFS_PERIPHERAL_FLAG, 8'h00);
		// software may also set the flag; it stays masked here
		wr_reg(OFS_PERIPHERAL_FLAG, 8'h04);
		expect_reg("flag set", OFS_PERIPHERAL_FLAG, 8'h04);
		// restarts every 30 cycles, 15 with both edges, against a 21-tick period
		wr_reg(OFS_LIMIT_PERIOD, 8'h14);
		for (int r = 0; r < 5; r++) begin
			@(posedge clk);
			psel <= rows[r][4:3];
			wr_reg(OFS_LIMIT_CONTROL1, 8'({rows[r][7:5], rows[r][2:1]}));
			wr_reg(OFS_LIMIT_CONTROL0, 8'h04);
			wr_reg(OFS_LIMIT_COUNT, 8'h00);
			wr_reg(OFS_PERIPHERAL_FLAG, 8'h00);
			@(posedge clk);
			run <= 1'b1;
			repeat (100) @(posedge clk);
			n = 0;
			repeat (1200) begin
				@(negedge clk);
				if (limit_match === 1'b1) n++;
			end
			check("restart blocks", 16'(!rows[r][0]), 16'(n != 0));
			if (rows[r][0]) expect_reg("flag", OFS_PERIPHERAL_FLAG, 8'h00);
			// stop just after an edge; the limit must then fire
			@(src);
			@(posedge clk);
			run <= 1'b0;
			if (rows[r][0]) begin
				wait_match(200, n);
				k = rows[r][2:1] == 2'h3 ? 80 : 60;
				check("limit after stop", 16'h1, 16'(n >= k && n <= 100));
			end
		end
		tally_and_finish;
	end
endmodule : test_hardware_limit_timer
